// [hdl/rsrb_bank.sv]
// rsrb_bank.sv: read-only status register bank of the radio core
// assumes: the serial port logic issues rd_en with rd_addr and takes rd_data next cycle
`timescale 1ns/1ps
`include "rsrb_map.svh"

// Behaviour
// - low wake timer byte reads timer bits 7 to 0
// - high wake timer byte reads timer bits 15 to 8
// - bit 7 checksum match, cleared on rx entry, valid with legacy packet mode
// - bits 6..3 carry carrier sense, preamble quality, channel clear, sync found
// - bit 2 is output two level before inversion
// - bit 0 is output zero level before inversion
// - synthesizer calibration word readable for test only
// - tx fill register: bit 7 underflow, bits 6..0 byte count
// - rx fill register: bit 7 overflow, bits 6..0 byte count
// - two rc calibration registers read result in 6..0, bit 7 zero
module rsrb_bank (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire rsrb_pkg::rsrb_status_t status,
  input  wire logic                  rx_entry,
  input  wire logic                  crc_check_done,
  input  wire logic                  crc_check_pass,
  input  wire rsrb_pkg::rsrb_read_t  rd_req,
  output logic [7:0]                 rd_data,
  output logic                       rd_valid
);

  // ********************************************************************
  // checksum flag
  // ********************************************************************
  logic crc_match;

  rsrb_crc_flag u_crc (
    .sys_clk        (sys_clk),
    .nrst           (nrst),
    .rx_entry       (rx_entry),
    .crc_check_done (crc_check_done),
    .crc_check_pass (crc_check_pass),
    .crc_match      (crc_match)
  );

  // ********************************************************************
  // read decode
  // ********************************************************************
  // reserved bit 1 reads zero
  function automatic logic [7:0] pkt_byte(input rsrb_pkg::rsrb_status_t s, input logic crc);
    logic [7:0] b;
    b = `RSRB_RESET_BYTE;
    b[`RSRB_BIT_CRC_OK]   = crc;
    b[`RSRB_BIT_CARRIER]  = s.carrier_sense;
    b[`RSRB_BIT_PREAMBLE] = s.preamble_quality_met;
    b[`RSRB_BIT_CLEAR]    = s.channel_clear_flag;
    b[`RSRB_BIT_SYNC]     = s.sync_found_flag;
    b[`RSRB_BIT_OUT_TWO]  = s.general_output_two;
    b[`RSRB_BIT_OUT_ZERO] = s.general_output_zero;
    return b;
  endfunction

  // fifo fill byte: flag on top, byte count below; tx and rx share the layout
  function automatic logic [7:0] fill_byte(input logic flag, input logic [6:0] count);
    logic [7:0] b;
    b                          = `RSRB_RESET_BYTE;
    b[`RSRB_BIT_FIFO_FLAG]     = flag;
    b[`RSRB_BIT_FIFO_FLAG-1:0] = count;
    return b;
  endfunction

  // rc result byte: the top bit is reserved and reads zero
  function automatic logic [7:0] rc_byte(input logic [6:0] value);
    return {1'h0, value};
  endfunction

  // the eight offsets of this bank; anything else reads as zero
  function automatic logic is_mapped(input logic [`RSRB_ADDR_W-1:0] a);
    return (a >= `RSRB_OFF_WAKE_HIGH) && (a <= `RSRB_OFF_RC_CAL_LOW);
  endfunction

  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic       rd_valid_q;
  logic       rd_valid_d;

  // pure mux: nothing here feeds back into status, so reads disturb nothing
  always_comb
  begin
    rd_valid_d = rd_req.rd_en;
    rd_data_d  = rd_data_q;
    if (rd_req.rd_en)
    begin
      case (rd_req.rd_addr)
        `RSRB_OFF_WAKE_HIGH:   rd_data_d = status.wake_time[15:8];
        `RSRB_OFF_WAKE_LOW:    rd_data_d = status.wake_time[7:0];
        `RSRB_OFF_PKT_STATUS:  rd_data_d = pkt_byte(status, crc_match);
        `RSRB_OFF_SYNTH_CAL:   rd_data_d = status.synth_cal_word;
        `RSRB_OFF_TX_FILL:
          rd_data_d = fill_byte(status.tx_underflow_flag, status.tx_byte_count);
        `RSRB_OFF_RX_FILL:
          rd_data_d = fill_byte(status.rx_overflow_flag, status.rx_byte_count);
        `RSRB_OFF_RC_CAL_HIGH: rd_data_d = rc_byte(status.rc_cal_high);
        `RSRB_OFF_RC_CAL_LOW:  rd_data_d = rc_byte(status.rc_cal_low);
        default:               rd_data_d = `RSRB_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      rd_data_q  <= `RSRB_RESET_BYTE;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;

  // ********************************************************************
  // checks
  // ********************************************************************
  sequence s_rd(logic [5:0] a);
    rd_req.rd_en && rd_req.rd_addr == a;
  endsequence

  a_wake_low_byte: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_WAKE_LOW) |=> rd_valid && rd_data == $past(status.wake_time[7:0]))
    else $error("wake low byte wrong");

  a_wake_high_byte: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_WAKE_HIGH) |=> rd_data == $past(status.wake_time[15:8]))
    else $error("wake high byte wrong");

  a_crc_rx_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    rx_entry ##1 !crc_check_done ##1 s_rd(`RSRB_OFF_PKT_STATUS) |=> !rd_data[7])
    else $error("checksum flag not cleared on rx entry");

  a_pkt_live_flags: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_PKT_STATUS) |=> rd_data[6:3] == $past({status.carrier_sense,
      status.preamble_quality_met, status.channel_clear_flag, status.sync_found_flag}))
    else $error("packet live flags wrong");

  a_out_two_raw: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_PKT_STATUS) |=> rd_data[2] == $past(status.general_output_two) && !rd_data[1])
    else $error("output two level wrong");

  a_out_zero_raw: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_PKT_STATUS) |=> rd_data[0] == $past(status.general_output_zero))
    else $error("output zero level wrong");

  a_synth_cal_word: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_SYNTH_CAL) |=> rd_data == $past(status.synth_cal_word))
    else $error("synth cal word wrong");

  a_tx_fill_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_TX_FILL)
      |=> rd_data == $past({status.tx_underflow_flag, status.tx_byte_count}))
    else $error("tx fill wrong");

  a_rx_fill_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_RX_FILL) |=> rd_data == $past({status.rx_overflow_flag, status.rx_byte_count}))
    else $error("rx fill wrong");

  a_rc_cal_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_RC_CAL_HIGH) or s_rd(`RSRB_OFF_RC_CAL_LOW)
      |=> !rd_data[7] && rd_data[6:0] == ($past(rd_req.rd_addr) == `RSRB_OFF_RC_CAL_HIGH
        ? $past(status.rc_cal_high) : $past(status.rc_cal_low)))
    else $error("rc cal result wrong");

  a_crc_read_stable: assert property (@(posedge sys_clk) disable iff (!nrst)
    rd_req.rd_en && !rx_entry && !crc_check_done |=> crc_match == $past(crc_match))
    else $error("read disturbed checksum flag");

  // ********************************************************************
  // checks on the answer and its fields
  // ********************************************************************
  // a read is taken with no wait state, so every request has its answer next cycle
  sequence s_rd_any;
    rd_req.rd_en;
  endsequence

  sequence s_bus_idle;
    !rd_req.rd_en;
  endsequence

  a_valid_follows: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd_any |=> rd_valid)
    else $error("read not answered");

  a_valid_one_cycle: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_bus_idle |=> !rd_valid)
    else $error("answer without request");

  a_data_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_bus_idle |=> $stable(rd_data))
    else $error("read data moved between reads");

  // unmapped places answer zero so a host scan finds no ghost registers
  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    rd_req.rd_en && !is_mapped(rd_req.rd_addr) |=> rd_data == `RSRB_RESET_BYTE)
    else $error("unmapped read not zero");

  a_carrier_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_PKT_STATUS)
      |=> rd_data[`RSRB_BIT_CARRIER] == $past(status.carrier_sense))
    else $error("carrier sense bit wrong");

  a_preamble_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_PKT_STATUS)
      |=> rd_data[`RSRB_BIT_PREAMBLE] == $past(status.preamble_quality_met))
    else $error("preamble quality bit wrong");

  a_clear_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_PKT_STATUS)
      |=> rd_data[`RSRB_BIT_CLEAR] == $past(status.channel_clear_flag))
    else $error("channel clear bit wrong");

  a_sync_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_PKT_STATUS)
      |=> rd_data[`RSRB_BIT_SYNC] == $past(status.sync_found_flag))
    else $error("sync found bit wrong");

  a_pkt_reserved_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_PKT_STATUS) |=> !rd_data[1])
    else $error("reserved status bit set");

  a_tx_flag_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_TX_FILL) |=> rd_data[7] == $past(status.tx_underflow_flag))
    else $error("tx underflow bit wrong");

  a_tx_count_bits: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_TX_FILL) |=> rd_data[6:0] == $past(status.tx_byte_count))
    else $error("tx byte count wrong");

  a_rx_flag_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_RX_FILL) |=> rd_data[7] == $past(status.rx_overflow_flag))
    else $error("rx overflow bit wrong");

  a_rx_count_bits: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_RX_FILL) |=> rd_data[6:0] == $past(status.rx_byte_count))
    else $error("rx byte count wrong");

  a_rc_high_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_RC_CAL_HIGH) |=> rd_data == {1'h0, $past(status.rc_cal_high)})
    else $error("rc high result wrong");

  a_rc_low_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rd(`RSRB_OFF_RC_CAL_LOW) |=> rd_data == {1'h0, $past(status.rc_cal_low)})
    else $error("rc low result wrong");

  // no disable here: this one watches the reset itself
  a_reset_idle: assert property (@(posedge sys_clk)
    !nrst |=> !rd_valid && rd_data == `RSRB_RESET_BYTE && !crc_match)
    else $error("reset left state behind");

  // ********************************************************************
  // checks on the checksum flag
  // ********************************************************************
  // restart in receive, with or without a result in the same cycle
  sequence s_rx_restart;
    rx_entry;
  endsequence

  sequence s_crc_pass;
    !rx_entry && crc_check_done && crc_check_pass;
  endsequence

  sequence s_crc_fail;
    !rx_entry && crc_check_done && !crc_check_pass;
  endsequence

  // nothing for the flag this cycle; reads alone must leave it where it is
  sequence s_crc_quiet;
    !rx_entry && !crc_check_done;
  endsequence

  a_crc_pass_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_crc_pass |=> crc_match)
    else $error("matched checksum not latched");

  a_crc_fail_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_crc_fail |=> !crc_match)
    else $error("failed checksum left flag set");

  a_crc_entry_wins: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rx_restart |=> !crc_match)
    else $error("rx entry did not clear flag");

  a_crc_quiet_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_crc_quiet |=> $stable(crc_match))
    else $error("checksum flag moved with no event");

  a_crc_read_pass: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_crc_pass ##1 s_crc_quiet ##1 s_rd(`RSRB_OFF_PKT_STATUS) |=> rd_data[7])
    else $error("matched checksum not reported");

  a_crc_read_fail: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_crc_fail ##1 s_crc_quiet ##1 s_rd(`RSRB_OFF_PKT_STATUS) |=> !rd_data[7])
    else $error("failed checksum reported as match");

  // a result arriving with the restart is stale and must not show up
  a_crc_tie_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    rx_entry && crc_check_done ##1 s_crc_quiet ##1 s_rd(`RSRB_OFF_PKT_STATUS) |=> !rd_data[7])
    else $error("stale result survived rx entry");

endmodule

// [hdl/rsrb_map.svh]
// rsrb_map.svh: register offsets and field positions of the radio status bank
// assumes: included by bare name from the package and the bank module
`ifndef RSRB_MAP_SVH
`define RSRB_MAP_SVH

`define RSRB_ADDR_W           6
`define RSRB_OFF_WAKE_HIGH    6'h36
`define RSRB_OFF_WAKE_LOW     6'h37
`define RSRB_OFF_PKT_STATUS   6'h38
`define RSRB_OFF_SYNTH_CAL    6'h39
`define RSRB_OFF_TX_FILL      6'h3A
`define RSRB_OFF_RX_FILL      6'h3B
`define RSRB_OFF_RC_CAL_HIGH  6'h3C
`define RSRB_OFF_RC_CAL_LOW   6'h3D
`define RSRB_BIT_CRC_OK       7
`define RSRB_BIT_CARRIER      6
`define RSRB_BIT_PREAMBLE     5
`define RSRB_BIT_CLEAR        4
`define RSRB_BIT_SYNC         3
`define RSRB_BIT_OUT_TWO      2
`define RSRB_BIT_OUT_ZERO     0
`define RSRB_BIT_FIFO_FLAG    7
`define RSRB_RESET_BYTE       8'h00

`endif

// [hdl/rsrb_pkg.sv]
// rsrb_pkg.sv: types shared by the radio status bank files
// assumes: rsrb_map.svh is on the include path
`include "rsrb_map.svh"
package rsrb_pkg;

  // live status gathered from the radio core
  typedef struct packed {
    logic [15:0] wake_time;
    logic        crc_match;
    logic        carrier_sense;
    logic        preamble_quality_met;
    logic        channel_clear_flag;
    logic        sync_found_flag;
    logic        general_output_two;
    logic        general_output_zero;
    logic [7:0]  synth_cal_word;
    logic        tx_underflow_flag;
    logic [6:0]  tx_byte_count;
    logic        rx_overflow_flag;
    logic [6:0]  rx_byte_count;
    logic [6:0]  rc_cal_high;
    logic [6:0]  rc_cal_low;
  } rsrb_status_t;

  typedef struct packed {
    logic                     rd_en;
    logic [`RSRB_ADDR_W-1:0]  rd_addr;
  } rsrb_read_t;

  typedef enum logic [1:0] {
    RSRB_CRC_IDLE  = 2'b00,
    RSRB_CRC_WAIT  = 2'b01,
    RSRB_CRC_VALID = 2'b10
  } rsrb_crc_state_t;

endpackage

// [hdl/rsrb_crc_flag.sv]
// rsrb_crc_flag.sv: checksum-match flag held between receive restarts
// assumes: check strobes and rx entry pulses are one cycle, synchronous to sys_clk
`timescale 1ns/1ps
module rsrb_crc_flag (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic rx_entry,
  input  wire logic crc_check_done,
  input  wire logic crc_check_pass,
  output logic      crc_match
);

  rsrb_pkg::rsrb_crc_state_t state_q;
  rsrb_pkg::rsrb_crc_state_t state_d;

  // entry to receive wins over a result in the same cycle: that result is stale
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      rsrb_pkg::RSRB_CRC_IDLE,
      rsrb_pkg::RSRB_CRC_WAIT,
      rsrb_pkg::RSRB_CRC_VALID:
      begin
        if (rx_entry)
          state_d = rsrb_pkg::RSRB_CRC_WAIT;
        else if (crc_check_done)
          state_d = crc_check_pass ? rsrb_pkg::RSRB_CRC_VALID : rsrb_pkg::RSRB_CRC_WAIT;
      end
      default: state_d = rsrb_pkg::RSRB_CRC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      state_q <= rsrb_pkg::RSRB_CRC_IDLE;
    else
      state_q <= state_d;
  end

  assign crc_match = (state_q == rsrb_pkg::RSRB_CRC_VALID);

endmodule

// [test/rsrb_host_model.sv]
// rsrb_host_model.sv: host side of the status bank, issues single reads
// assumes: the bank answers one cycle after the request edge
`timescale 1ns/1ps
module rsrb_host_model (
  input  wire logic            sys_clk,
  output rsrb_pkg::rsrb_read_t rd_req,
  input  wire logic [7:0]      rd_data,
  input  wire logic            rd_valid
);
  // ****************
  // read cycle
  // ****************
  // lock is never judged from the output pin bits here
  initial rd_req = '0;
  task automatic read_reg(input logic [5:0] addr, output logic [7:0] data,
                          output logic vld);
    @(posedge sys_clk);
    rd_req <= '{rd_en: 1'b1, rd_addr: addr};
    @(posedge sys_clk);
    // released address lines show a changed value, not the old one
    rd_req <= '{rd_en: 1'b0, rd_addr: ~addr};
    #1;
    data = rd_data;
    vld  = rd_valid;
  endtask
endmodule

// [test/tb_radio_status_register_bank.sv]
// tb_radio_status_register_bank.sv: self-checking bench of the status bank
// assumes: rsrb_pkg compiled first, host model reads through its task
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_radio_status_register_bank;
  // ****************
  // harness
  // ****************
  logic                   sys_clk = 1'b0;
  logic                   nrst = 1'b0;
  rsrb_pkg::rsrb_status_t st = '0;
  logic                   rx_entry = 1'b0;
  logic                   crc_check_done = 1'b0;
  logic                   crc_check_pass = 1'b0;
  rsrb_pkg::rsrb_read_t   rd_req;
  logic [7:0]             rd_data;
  logic                   rd_valid;
  int                     mismatches = 0;
  int                     samples_checked = 0;
  int                     cycles = 0;
  always #5 sys_clk = ~sys_clk;
  rsrb_bank i_dut (.sys_clk(sys_clk), .nrst(nrst), .status(st), .rx_entry(rx_entry),
    .crc_check_done(crc_check_done), .crc_check_pass(crc_check_pass),
    .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid));
  rsrb_host_model i_host (.sys_clk(sys_clk), .rd_req(rd_req), .rd_data(rd_data),
    .rd_valid(rd_valid));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // the run needs about eighty cycles; a hang is cut short well above that
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  function automatic logic [7:0] exp_byte(input logic [5:0] a, input logic crc);
    case (a)
      6'h36: return st.wake_time[15:8];
      6'h37: return st.wake_time[7:0];
      6'h38: return {crc, st.carrier_sense, st.preamble_quality_met, st.channel_clear_flag,
                     st.sync_found_flag, st.general_output_two, 1'b0, st.general_output_zero};
      6'h39: return st.synth_cal_word;
      6'h3A: return {st.tx_underflow_flag, st.tx_byte_count};
      6'h3B: return {st.rx_overflow_flag, st.rx_byte_count};
      6'h3C: return {1'b0, st.rc_cal_high};
      6'h3D: return {1'b0, st.rc_cal_low};
      default: return 8'h00;
    endcase
  endfunction
  task automatic rd_check(input logic [5:0] a, output logic [7:0] d);
    logic v;
    i_host.read_reg(a, d, v);
    `CHK("rd_valid", 1'b1, v)
  endtask
  // ****************
  // scenarios
  // ****************
  // every field under two complementary patterns, plus unmapped places
  task automatic t_fields();
    logic [7:0] d;
    logic [5:0] a;
    for (int p = 0; p < 2; p++)
    begin
      @(posedge sys_clk);
      st <= p ? 61'h1A53_C96E_10F5_AC3B : ~61'h1A53_C96E_10F5_AC3B;
      for (int i = 0; i < 10; i++)
      begin
        a = (i < 8) ? 6'(6'h36 + i) : ((i == 8) ? 6'h00 : 6'h3F);
        rd_check(a, d);
        `CHK("reg", exp_byte(a, 1'b0), d)
        `CHK("reg", exp_byte(a, 1'b0), d)
      end
    end
    $display("t_fields done");
  endtask
  // checksum flag: set, held across reads, cleared by rx entry, entry wins a tie
  task automatic t_crc();
    logic [3:0] tab [6] = '{4'h7, 4'h1, 4'h8, 4'h4, 4'h7, 4'hE};
    logic [7:0] d;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge sys_clk);
      {rx_entry, crc_check_done, crc_check_pass} <= tab[i][3:1];
      @(posedge sys_clk);
      {rx_entry, crc_check_done, crc_check_pass} <= 3'h0;
      rd_check(6'h38, d);
      `CHK("crc_match", tab[i][0], d[7])
      `CHK("pkt", exp_byte(6'h38, tab[i][0]), d)
    end
    $display("t_crc done");
  endtask
  // mid-run reset with the flag set: outputs and flag go back to idle
  task automatic t_reset();
    logic [7:0] d;
    @(posedge sys_clk);
    {crc_check_done, crc_check_pass} <= 2'h3;
    @(posedge sys_clk);
    {crc_check_done, crc_check_pass} <= 2'h0;
    rd_check(6'h38, d);
    `CHK("crc_before_reset", 1'b1, d[7])
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    `CHK("rst_valid", 1'b0, rd_valid)
    `CHK("rst_data", 8'h00, rd_data)
    rd_check(6'h38, d);
    `CHK("crc_after_reset", 1'b0, d[7])
    `CHK("pkt_after_reset", exp_byte(6'h38, 1'b0), d)
    $display("t_reset done");
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    t_fields();
    t_crc();
    t_reset();
    give_verdict();
  end
endmodule
